// file: hw/lane_rx_framer.sv
// Purpose: In-frame / out-of-frame tracking on the A1-to-A2 boundary.
// Assumes: Match strobe comes from the A1/A2 byte compare, check strobe from the lane's receive counters.
// Notes: Two good frames to lock, four bad in a row to drop.
`timescale 1ns/1ps
`default_nettype none
module lane_rx_framer
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_en,
  input wire logic i_check,
  input wire logic i_match,
  output sonet_lane_pkg::frm_st_t o_state,
  output logic o_load,
  output logic o_oof_evt
);
  import sonet_lane_pkg::*;
  typedef struct packed {
    frm_st_t state;
    logic [1:0] cnt;
  } fst_t;
  fst_t st_ff;
  fst_t nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    o_load = 1'b0;
    o_oof_evt = 1'b0;
    case (st_ff.state)
      FR_HUNT:
        if (i_match)
        begin
          o_load = 1'b1;
          nxt_st.state = FR_PRESYNC;
          nxt_st.cnt = 2'h0;
        end
      FR_PRESYNC:
        if (i_check)
        begin
          if (!i_match)
            nxt_st.state = FR_HUNT;
          else if (st_ff.cnt == HIT_LAST)
          begin
            nxt_st.state = FR_SYNC;
            nxt_st.cnt = 2'h0;
          end
          else
            nxt_st.cnt = st_ff.cnt + 2'h1;
        end
      FR_SYNC:
        if (i_check)
        begin
          if (i_match)
            nxt_st.cnt = 2'h0;
          else if (st_ff.cnt == MISS_LAST)
          begin
            nxt_st.state = FR_HUNT;
            o_oof_evt = 1'b1;
          end
          else
            nxt_st.cnt = st_ff.cnt + 2'h1;
        end
      default:
        nxt_st.state = FR_HUNT;
    endcase
    if (!i_en)
    begin
      nxt_st.state = FR_HUNT;
      nxt_st.cnt = 2'h0;
      o_load = 1'b0;
      o_oof_evt = 1'b0;
    end
  end

  assign o_state = st_ff.state;

  always_ff @(posedge i_clk or negedge i_rst_b)
    if (!i_rst_b)
      st_ff <= '{state: FR_HUNT, cnt: 2'h0};
    else
      st_ff <= nxt_st;
endmodule
`default_nettype wire

// file: hw/lane_scrambler.sv
// Purpose: Frame-synchronous 1+x^6+x^7 keystream, eight bits per clock.
// Assumes: Caller reseeds at the last unscrambled byte of each frame.
// Notes: Same module serves transmit scrambling and receive descrambling.
`timescale 1ns/1ps
`default_nettype none
module lane_scrambler
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_clr,
  input wire logic i_adv,
  output logic [7:0] o_key
);
  import sonet_lane_pkg::*;
  logic [6:0] lfsr_ff;
  logic [6:0] nxt_lfsr;

  always_comb
  begin
    nxt_lfsr = lfsr_ff;
    o_key = 8'h00;
    for (int i = 7; i >= 0; i--)
    begin
      o_key[i] = nxt_lfsr[6];
      nxt_lfsr = {nxt_lfsr[5:0], nxt_lfsr[6] ^ nxt_lfsr[5]};
    end
    if (i_clr)
      nxt_lfsr = SCR_SEED;
    else if (!i_adv)
      nxt_lfsr = lfsr_ff;
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
    if (!i_rst_b)
      lfsr_ff <= SCR_SEED;
    else
      lfsr_ff <= nxt_lfsr;
endmodule
`default_nettype wire

// file: hw/sonet_lane_framer_scrambler.sv
// Purpose: One lane of pseudo-SONET transmit overhead, scrambling and receive framing.
// Assumes: i_clk is the serializer byte clock; fabric words move every fourth byte.
// Notes: Registers sit on a plain 8-bit port; read data appears one cycle later.
// Behaviour
// - Bytes to serializer, words every fourth byte
// - Word rate is byte rate divided by four
// - Transport overhead is first 144 row bytes
// - Overhead passed through or auto-inserted, three modes
// - Framing corruption sends A1/A2 inverted
// - Parity force sends B1 inverted
// - Fault injection sends K2 as 00000110
// - Receiver flags framing, parity and K2 faults
// - Framed 32-bit words with one-cycle frame pulse
// - Track in/out of frame, alarm on loss
// - Scramble transmit with 1+x^6+x^7
// - Descramble receive with same polynomial
// - Lane group mode: solo, pair, quad, eight
// - Powering lane down leaves other lanes alone
// - Rejoin allowed only after earlier aligned membership
// - Register-controlled near and far loopback
// - 8-bit register port, lane and shared
// - Payload envelope flag beside receive words
// - Optional bypass of the alignment stage
`timescale 1ns/1ps
`default_nettype none
module sonet_lane_framer_scrambler
#(
  parameter int ROW_BYTES = sonet_lane_pkg::ROW_BYTES_DFLT
)
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire sonet_lane_pkg::reg_req_t i_reg,
  output logic [7:0] o_rdata,
  input wire logic [31:0] i_tx_word,
  output logic o_tx_take,
  output logic o_tx_frame_start,
  output logic [7:0] o_ser_byte,
  input wire logic [7:0] i_des_byte,
  output sonet_lane_pkg::rx_word_t o_rx,
  output logic o_oof,
  output sonet_lane_pkg::group_t o_group_mode,
  output logic o_rejoin_ok
);
  import sonet_lane_pkg::*;

  localparam col_t LAST_COL = col_t'(ROW_BYTES - 1);
  localparam col_t PRE_COL = col_t'(ROW_BYTES - 2);

  typedef struct packed {
    ctrl_t ctrl;
    fault_t fault;
    group_t grp;
    logic [2:0] sticky;
    logic member;
    logic oof;
    logic [7:0] rdata;
    col_t tcol;
    row_t trow;
    logic take;
    logic tx_fs;
    logic [31:0] tword;
    logic [7:0] tbip;
    logic [7:0] tbip_last;
    logic [7:0] ser;
    col_t rcol;
    row_t rrow;
    logic [7:0] rprev;
    logic [7:0] rbip;
    logic [7:0] rbip_last;
    logic [23:0] racc;
    rx_word_t ralign;
    rx_word_t rx;
  } st_t;

  st_t st_ff;
  st_t nxt_st;
  logic [7:0] tkey;
  logic [7:0] rkey;
  logic [7:0] rin;
  logic [7:0] fab_b;
  logic [7:0] tx_b;
  logic [7:0] rdesc;
  logic [2:0] st_set;
  logic [2:0] st_clr;
  logic frm_match;
  logic frm_check;
  logic frm_load;
  logic frm_oof_evt;
  logic lane_on;
  frm_st_t frm_state;
  rx_word_t word_n;

  // Unscrambled region: first row of overhead, where A1/A2 must stay visible
  function automatic logic unscr(row_t r, col_t c);
    return (r == ROW_ZERO) && (c < TOH_COLS);
  endfunction

  function automatic logic a1a2_pos(row_t r, col_t c);
    return (r == ROW_ZERO) && (c < A2_END);
  endfunction

  assign lane_on = st_ff.ctrl.sonet && !st_ff.ctrl.pwr_down;
  assign rin = st_ff.ctrl.near_lb ? st_ff.ser : i_des_byte;
  assign fab_b = st_ff.tword[{~st_ff.tcol[1:0], 3'h0} +: 8];
  assign frm_match = (st_ff.rprev == A1_BYTE) && (rin == A2_BYTE);
  assign frm_check = (st_ff.rrow == ROW_ZERO) && (st_ff.rcol == A2_COL);
  assign rdesc = (st_ff.ctrl.sonet && !unscr(st_ff.rrow, st_ff.rcol)) ? rin ^ rkey : rin;

  lane_scrambler u_tx_scr
  (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_clr((st_ff.trow == ROW_ZERO) && (st_ff.tcol == TOH_LAST)),
    .i_adv(!unscr(st_ff.trow, st_ff.tcol)),
    .o_key(tkey)
  );

  lane_scrambler u_rx_scr
  (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_clr((st_ff.rrow == ROW_ZERO) && (st_ff.rcol == TOH_LAST)),
    .i_adv(!unscr(st_ff.rrow, st_ff.rcol)),
    .o_key(rkey)
  );

  lane_rx_framer u_frm
  (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_en(lane_on),
    .i_check(frm_check),
    .i_match(frm_match),
    .o_state(frm_state),
    .o_load(frm_load),
    .o_oof_evt(frm_oof_evt)
  );

  always_comb
  begin
    nxt_st = st_ff;
    st_set = 3'h0;
    st_clr = 3'h0;
    word_n = '0;
    // Transmit byte build
    tx_b = fab_b;
    if (st_ff.ctrl.sonet)
    begin
      if ((st_ff.tcol < TOH_COLS) && (st_ff.ctrl.toh_mode != TOH_PASS))
      begin
        if (st_ff.ctrl.toh_mode != TOH_SOH)
          tx_b = TOH_FILL;
        if (a1a2_pos(st_ff.trow, st_ff.tcol))
          tx_b = (st_ff.tcol < A2_COL) ? A1_BYTE : A2_BYTE;
        if ((st_ff.trow == B1_ROW) && (st_ff.tcol == COL_ZERO))
          tx_b = st_ff.tbip_last;
      end
      if (a1a2_pos(st_ff.trow, st_ff.tcol) && st_ff.fault.a1a2_inv)
        tx_b = ~tx_b;
      if ((st_ff.trow == B1_ROW) && (st_ff.tcol == COL_ZERO) && st_ff.fault.b1_force)
        tx_b = ~tx_b;
      if ((st_ff.trow == K2_ROW) && (st_ff.tcol == K2_COL) && st_ff.fault.k2_inj)
        tx_b = K2_RDI;
      if (!unscr(st_ff.trow, st_ff.tcol))
        tx_b = tx_b ^ tkey;
    end
    // Parity runs over the built byte after scrambling, ahead of the loopback and power-down selects
    if ((st_ff.tcol == LAST_COL) && (st_ff.trow == LAST_ROW))
    begin
      nxt_st.tbip_last = st_ff.tbip ^ tx_b;
      nxt_st.tbip = 8'h00;
    end
    else
      nxt_st.tbip = st_ff.tbip ^ tx_b;
    if (st_ff.ctrl.far_lb)
      nxt_st.ser = i_des_byte;
    else if (st_ff.ctrl.pwr_down)
      nxt_st.ser = 8'h00;
    else
      nxt_st.ser = tx_b;
    // One word per four bytes; byte position doubles as the word phase
    if (st_ff.tcol == LAST_COL)
    begin
      nxt_st.tcol = COL_ZERO;
      nxt_st.trow = (st_ff.trow == LAST_ROW) ? ROW_ZERO : st_ff.trow + 4'h1;
    end
    else
      nxt_st.tcol = st_ff.tcol + 13'h0001;
    nxt_st.take = (st_ff.tcol[1:0] == PH_PRE);
    nxt_st.tx_fs = st_ff.ctrl.sonet && (st_ff.tcol == PRE_COL) && (st_ff.trow == LAST_ROW);
    if (st_ff.take)
      nxt_st.tword = i_tx_word;
    // Receive counters; an A1/A2 match in hunt re-phases them to the first A2 byte
    if (frm_load)
    begin
      nxt_st.rcol = A2_COL + 13'h0001;
      nxt_st.rrow = ROW_ZERO;
    end
    else if (st_ff.rcol == LAST_COL)
    begin
      nxt_st.rcol = COL_ZERO;
      nxt_st.rrow = (st_ff.rrow == LAST_ROW) ? ROW_ZERO : st_ff.rrow + 4'h1;
    end
    else
      nxt_st.rcol = st_ff.rcol + 13'h0001;
    nxt_st.rprev = rin;
    if ((st_ff.rcol == LAST_COL) && (st_ff.rrow == LAST_ROW))
    begin
      nxt_st.rbip_last = st_ff.rbip ^ rin;
      nxt_st.rbip = 8'h00;
    end
    else
      nxt_st.rbip = st_ff.rbip ^ rin;
    if (frm_state == FR_SYNC)
    begin
      if ((st_ff.rrow == B1_ROW) && (st_ff.rcol == COL_ZERO) && (rdesc != st_ff.rbip_last))
        st_set[1] = 1'b1;
      if ((st_ff.rrow == K2_ROW) && (st_ff.rcol == K2_COL) && (rdesc[2:0] == K2_RDI_CODE))
        st_set[2] = 1'b1;
    end
    st_set[0] = frm_oof_evt;
    // Rise together with the sticky bit, not one cycle after the framer drops
    nxt_st.oof = lane_on && ((frm_state != FR_SYNC) || frm_oof_evt);
    // Word assembly
    nxt_st.racc = {st_ff.racc[15:0], rdesc};
    if (st_ff.rcol[1:0] == PH_LAST)
    begin
      word_n.data = {st_ff.racc, rdesc};
      word_n.valid = !st_ff.ctrl.pwr_down && (!st_ff.ctrl.sonet || (frm_state == FR_SYNC));
      word_n.frame_start = word_n.valid && st_ff.ctrl.sonet && (st_ff.rrow == ROW_ZERO)
                           && (st_ff.rcol == FIRST_WORD_END);
      word_n.spe = word_n.valid && st_ff.ctrl.sonet && (st_ff.rcol > TOH_LAST);
    end
    nxt_st.ralign = word_n;
    nxt_st.rx = st_ff.ctrl.align_bypass ? word_n : st_ff.ralign;
    // A powered-down lane only silences itself; membership survives for a later rejoin
    if (lane_on && (st_ff.grp != GRP_SOLO) && (frm_state == FR_SYNC))
      nxt_st.member = 1'b1;
    // Register port
    nxt_st.rdata = 8'h00;
    if (i_reg.wr)
    begin
      if (i_reg.addr == ADDR_CTRL)
        nxt_st.ctrl = ctrl_t'(i_reg.wdata[6:0]);
      else if (i_reg.addr == ADDR_FAULT)
        nxt_st.fault = fault_t'(i_reg.wdata[2:0]);
      else if (i_reg.addr == ADDR_STAT)
        st_clr = i_reg.wdata[2:0];
      else if (i_reg.addr == ADDR_GROUP)
      begin
        nxt_st.grp = group_t'(i_reg.wdata[1:0]);
        if (group_t'(i_reg.wdata[1:0]) == GRP_SOLO)
          nxt_st.member = 1'b0;
      end
    end
    // Hardware set beats a software clear in the same cycle
    nxt_st.sticky = (st_ff.sticky & ~st_clr) | st_set;
    if (i_reg.rd)
    begin
      if (i_reg.addr == ADDR_CTRL)
        nxt_st.rdata = {1'b0, st_ff.ctrl};
      else if (i_reg.addr == ADDR_FAULT)
        nxt_st.rdata = {5'h00, st_ff.fault};
      else if (i_reg.addr == ADDR_STAT)
        nxt_st.rdata = {3'h0, st_ff.member, frm_state == FR_SYNC, st_ff.sticky};
      else if (i_reg.addr == ADDR_GROUP)
        nxt_st.rdata = {6'h00, st_ff.grp};
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
    if (!i_rst_b)
      st_ff <= '0;
    else
      st_ff <= nxt_st;

  assign o_rdata = st_ff.rdata;
  assign o_tx_take = st_ff.take;
  assign o_tx_frame_start = st_ff.tx_fs;
  assign o_ser_byte = st_ff.ser;
  assign o_rx = st_ff.rx;
  assign o_oof = st_ff.oof;
  assign o_group_mode = st_ff.grp;
  assign o_rejoin_ok = st_ff.member;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  logic tx_live;
  assign tx_live = st_ff.ctrl.sonet && !st_ff.ctrl.far_lb && !st_ff.ctrl.pwr_down;

  property p_take_period;
    o_tx_take |=> !o_tx_take [*3] ##1 o_tx_take;
  endproperty
  a_take_period: assert property (p_take_period) else $error("word take not every fourth byte");

  property p_a1_inv;
    (tx_live && st_ff.fault.a1a2_inv && (st_ff.ctrl.toh_mode != TOH_PASS)
      && (st_ff.trow == ROW_ZERO) && (st_ff.tcol == COL_ZERO)) |=> (o_ser_byte == ~A1_BYTE);
  endproperty
  a_a1_inv: assert property (p_a1_inv) else $error("A1 not inverted");

  property p_a2_auto;
    (tx_live && !st_ff.fault.a1a2_inv && (st_ff.ctrl.toh_mode == TOH_FULL)
      && (st_ff.trow == ROW_ZERO) && (st_ff.tcol == A2_COL)) |=> (o_ser_byte == A2_BYTE);
  endproperty
  a_a2_auto: assert property (p_a2_auto) else $error("A2 not inserted");

  property p_toh_pass;
    (tx_live && (st_ff.ctrl.toh_mode == TOH_PASS) && (st_ff.trow == ROW_ZERO)
      && (st_ff.tcol > A2_END) && (st_ff.tcol < TOH_COLS)) |=> (o_ser_byte == $past(fab_b));
  endproperty
  a_toh_pass: assert property (p_toh_pass) else $error("overhead not passed through");

  property p_fs_width;
    o_rx.frame_start |=> !o_rx.frame_start [*3];
  endproperty
  a_fs_width: assert property (p_fs_width) else $error("frame pulse wider than one word");

  property p_fs_valid;
    o_rx.frame_start |-> (o_rx.valid && !o_rx.spe && !o_oof);
  endproperty
  a_fs_valid: assert property (p_fs_valid) else $error("frame pulse on a bad word");

  property p_oof_alarm;
    frm_oof_evt |=> (o_oof && st_ff.sticky[0]);
  endproperty
  a_oof_alarm: assert property (p_oof_alarm) else $error("loss of frame not flagged");

  property p_set_wins;
    (st_set[1] && i_reg.wr && (i_reg.addr == ADDR_STAT) && i_reg.wdata[1]) |=> st_ff.sticky[1];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("parity flag lost to clear");

  property p_rdata_slot;
    !i_reg.rd |=> (o_rdata == 8'h00);
  endproperty
  a_rdata_slot: assert property (p_rdata_slot) else $error("read data outside its slot");

  property p_align_delay;
    (!st_ff.ctrl.align_bypass && word_n.valid) ##1 !st_ff.ctrl.align_bypass |=> o_rx.valid;
  endproperty
  a_align_delay: assert property (p_align_delay) else $error("alignment stage latency wrong");

  property p_pwr_quiet;
    (st_ff.ctrl.pwr_down && !st_ff.ctrl.far_lb) |=> (o_ser_byte == 8'h00)
      ##1 (!o_rx.valid || !$past(st_ff.ctrl.pwr_down));
  endproperty
  a_pwr_quiet: assert property (p_pwr_quiet) else $error("powered-down lane still active");

  c_frame_start: cover property (o_rx.frame_start);
  c_b1_err: cover property (st_set[1]);
  c_rdi: cover property (st_set[2]);
  c_oof: cover property (frm_oof_evt);
endmodule
`default_nettype wire

// file: hw/sonet_lane_pkg.sv
// Purpose: Shared constants and types for the per-lane SONET framer/scrambler.
// Assumes: Byte-aligned serializer bytes; one byte per clock.
// Notes: Frame geometry is STS-48 style, byte interleaved.
package sonet_lane_pkg;
  typedef logic [12:0] col_t;
  typedef logic [3:0] row_t;
  localparam int ROW_BYTES_DFLT = 4320;
  localparam row_t ROW_ZERO = 4'h0;
  localparam row_t LAST_ROW = 4'h8;
  localparam row_t B1_ROW = 4'h1;
  localparam row_t K2_ROW = 4'h4;
  localparam col_t COL_ZERO = 13'h0000;
  localparam col_t TOH_COLS = 13'h0090;
  localparam col_t TOH_LAST = 13'h008F;
  localparam col_t A2_COL = 13'h0030;
  localparam col_t A2_END = 13'h0060;
  localparam col_t K2_COL = 13'h0060;
  localparam col_t FIRST_WORD_END = 13'h0003;
  localparam logic [7:0] A1_BYTE = 8'hF6;
  localparam logic [7:0] A2_BYTE = 8'h28;
  localparam logic [7:0] K2_RDI = 8'h06;
  localparam logic [2:0] K2_RDI_CODE = 3'h6;
  localparam logic [7:0] TOH_FILL = 8'h00;
  localparam logic [6:0] SCR_SEED = 7'h7F;
  localparam logic [1:0] PH_PRE = 2'h2;
  localparam logic [1:0] PH_LAST = 2'h3;
  localparam logic [1:0] HIT_LAST = 2'h1;
  localparam logic [1:0] MISS_LAST = 2'h3;
  localparam int WCLK_MIN_KHZ = 18750;
  localparam int WCLK_MAX_KHZ = 84380;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_FAULT = 4'h1;
  localparam logic [3:0] ADDR_STAT = 4'h2;
  localparam logic [3:0] ADDR_GROUP = 4'h3;
  typedef enum logic [1:0] {TOH_PASS = 2'h0, TOH_SOH = 2'h1, TOH_FULL = 2'h2} toh_mode_t;
  typedef enum logic [1:0] {GRP_SOLO = 2'h0, GRP_PAIR = 2'h1, GRP_QUAD = 2'h2, GRP_ALL = 2'h3} group_t;
  typedef enum logic [2:0] {FR_HUNT = 3'b001, FR_PRESYNC = 3'b010, FR_SYNC = 3'b100} frm_st_t;
  typedef struct packed {
    logic pwr_down;
    logic align_bypass;
    logic far_lb;
    logic near_lb;
    logic sonet;
    toh_mode_t toh_mode;
  } ctrl_t;
  typedef struct packed {
    logic k2_inj;
    logic b1_force;
    logic a1a2_inv;
  } fault_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  typedef struct packed {
    logic [31:0] data;
    logic valid;
    logic frame_start;
    logic spe;
  } rx_word_t;
endpackage

// file: test/far_xcvr.sv
// Purpose: Far-end transceiver model that returns or sources line bytes.
// Assumes: Byte aligned line, one byte per clock.
// Notes: Mode 0 echoes after one cycle, 1 after five, 2 sends a running count.
`timescale 1ns/1ps
`default_nettype none
module far_xcvr
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [1:0] i_mode,
  input wire logic [7:0] i_line,
  output logic [7:0] o_line
);
  logic [7:0] dly_ff [5];
  logic [7:0] cnt_ff;
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      dly_ff <= '{default: 8'hA5};
      cnt_ff <= 8'h00;
    end
    else
    begin
      dly_ff[0] <= i_line;
      for (int i = 1; i < 5; i++)
        dly_ff[i] <= dly_ff[i - 1];
      cnt_ff <= cnt_ff + 8'h01;
    end
  end
  // Echo keeps frame geometry and scrambling intact
  assign o_line = (i_mode == 2'h2) ? cnt_ff : (i_mode == 2'h1) ? dly_ff[4] : dly_ff[0];
endmodule
`default_nettype wire

// file: test/tb_top.sv
// Purpose: Register, transmit, receive and fault checks for one lane.
// Assumes: Short rows of 200 bytes; far end echoes the line.
// Notes: Expected scrambled payload uses the keystream head FE 04 18 51.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sonet_lane_pkg::*;
  localparam int RB = 200;
  localparam logic [31:0] TXW = 32'h5A5AC3C3;
  logic i_clk;
  logic i_rst_b;
  reg_req_t i_reg;
  logic [7:0] o_rdata;
  logic [31:0] i_tx_word;
  logic o_tx_take;
  logic o_tx_frame_start;
  logic [7:0] o_ser_byte;
  logic [7:0] i_des_byte;
  rx_word_t o_rx;
  logic o_oof;
  group_t o_group_mode;
  logic o_rejoin_ok;
  logic [1:0] far_mode;
  logic [7:0] txr [148];
  logic [31:0] w;
  logic s;
  logic [7:0] p;
  int mismatches;
  int n_checks;
  int cnt;

  sonet_lane_framer_scrambler #(.ROW_BYTES(RB)) dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_reg(i_reg),
    .o_rdata(o_rdata), .i_tx_word(i_tx_word), .o_tx_take(o_tx_take), .o_tx_frame_start(o_tx_frame_start),
    .o_ser_byte(o_ser_byte), .i_des_byte(i_des_byte), .o_rx(o_rx), .o_oof(o_oof),
    .o_group_mode(o_group_mode), .o_rejoin_ok(o_rejoin_ok));
  far_xcvr far (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_mode(far_mode), .i_line(o_ser_byte), .o_line(i_des_byte));

  initial
  begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_reg <= {a, d, 2'b10};
    @(posedge i_clk);
    i_reg <= '0;
  endtask

  task automatic rdm(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] mask);
    @(posedge i_clk);
    i_reg <= {a, 8'h00, 2'b01};
    @(posedge i_clk);
    i_reg <= '0;
    @(negedge i_clk);
    chk8(o_rdata & mask, exp);
  endtask

  task automatic frames(input int n);
    repeat (n * 9 * RB) @(posedge i_clk);
  endtask

  task automatic wait_oof(input logic v);
    int n;
    n = 0;
    repeat (4) @(negedge i_clk);
    while (o_oof !== v && n < 12000)
    begin
      @(negedge i_clk);
      n++;
    end
    chk8({7'h0, o_oof}, {7'h0, v});
  endtask

  // Bytes leave back to back, so one row head is read straight off the line
  task automatic tx_row();
    int n;
    n = 0;
    do
    begin
      @(negedge i_clk);
      n++;
    end
    while (!(o_tx_take === 1'b1 && o_tx_frame_start === 1'b1) && n < 4000);
    repeat (2) @(posedge i_clk);
    for (int i = 0; i < 148; i++)
    begin
      @(negedge i_clk);
      txr[i] = o_ser_byte;
    end
  endtask

  function automatic logic [31:0] txw(input int c);
    return {txr[c], txr[c + 1], txr[c + 2], txr[c + 3]};
  endfunction

  task automatic rx_find();
    int n;
    n = 0;
    do
    begin
      @(negedge i_clk);
      n++;
    end
    while (!(o_rx.valid === 1'b1 && o_rx.frame_start === 1'b1) && n < 4000);
    chk32(o_rx.data, 32'hF6F6F6F6);
  endtask

  task automatic rx_next(input int k);
    int n;
    for (int j = 0; j < k; j++)
    begin
      n = 0;
      do
      begin
        @(negedge i_clk);
        n++;
        if (n == 1 && j == 0)
          chk8({7'h0, o_rx.frame_start}, 8'h00);
      end
      while (o_rx.valid !== 1'b1 && n < 8);
      chk8(n[7:0], 8'h04);
    end
    w = o_rx.data;
    s = o_rx.spe;
  endtask

  initial
  begin
    i_rst_b = 1'b0;
    i_reg = '0;
    i_tx_word = TXW;
    far_mode = 2'h0;
    mismatches = 0;
    n_checks = 0;
    repeat (8) @(posedge i_clk);
    i_rst_b <= 1'b1;
    for (int i = 0; i < 4; i++)
      rdm(i[3:0], 8'h00, 8'hFF);
    wr(4'hF, 8'hFF);
    rdm(4'hF, 8'h00, 8'hFF);
    rdm(ADDR_CTRL, 8'h00, 8'hFF);
    wr(ADDR_CTRL, 8'hFF);
    rdm(ADDR_CTRL, 8'h7F, 8'hFF);
    wr(ADDR_FAULT, 8'hFF);
    rdm(ADDR_FAULT, 8'h07, 8'hFF);
    for (int g = 0; g < 4; g++)
    begin
      wr(ADDR_GROUP, 8'hFC | g[7:0]);
      rdm(ADDR_GROUP, g[7:0], 8'hFF);
      chk8({6'h0, o_group_mode}, g[7:0]);
    end
    wr(ADDR_FAULT, 8'h00);
    wr(ADDR_GROUP, 8'h00);
    $display("registers finished");
    for (int m = 0; m < 4; m++)
    begin
      wr(ADDR_CTRL, 8'h04 | m[7:0]);
      tx_row();
      chk32(txw(0), m == 0 ? TXW : 32'hF6F6F6F6);
      chk32(txw(48), m == 0 ? TXW : 32'h28282828);
      chk32(txw(96), m < 2 ? TXW : 32'h00000000);
      chk32(txw(144), TXW ^ 32'hFE041851);
    end
    $display("transmit modes finished");
    for (int b = 0; b < 2; b++)
    begin
      wr(ADDR_CTRL, b == 0 ? 8'h06 : 8'h26);
      wait_oof(1'b0);
      rdm(ADDR_STAT, 8'h08, 8'h08);
      rx_find();
      rx_next(12);
      chk32(w, 32'h28282828);
      rx_next(23);
      chk32(w, 32'h00000000);
      chk8({7'h0, s}, 8'h00);
      rx_next(1);
      chk32(w, TXW);
      chk8({7'h0, s}, 8'h01);
    end
    wr(ADDR_GROUP, 8'h01);
    repeat (4) @(negedge i_clk);
    chk8({7'h0, o_rejoin_ok}, 8'h01);
    rdm(ADDR_STAT, 8'h18, 8'h18);
    $display("receive finished");
    wr(ADDR_FAULT, 8'h04);
    frames(2);
    rdm(ADDR_STAT, 8'h0C, 8'h0C);
    wr(ADDR_FAULT, 8'h02);
    frames(1);
    wr(ADDR_STAT, 8'h07);
    frames(2);
    rdm(ADDR_STAT, 8'h0A, 8'h0E);
    wr(ADDR_FAULT, 8'h00);
    frames(1);
    wr(ADDR_STAT, 8'h07);
    frames(1);
    rdm(ADDR_STAT, 8'h08, 8'h0F);
    wr(ADDR_FAULT, 8'h01);
    tx_row();
    chk32(txw(0), 32'h09090909);
    chk32(txw(48), 32'hD7D7D7D7);
    wait_oof(1'b1);
    rdm(ADDR_STAT, 8'h01, 8'h09);
    wr(ADDR_FAULT, 8'h00);
    wait_oof(1'b0);
    $display("faults finished");
    wr(ADDR_CTRL, 8'h66);
    // A word finished just before power-down may still emerge once
    @(negedge i_clk);
    cnt = 0;
    repeat (40)
    begin
      @(negedge i_clk);
      if (o_rx.valid === 1'b1)
        cnt++;
    end
    chk8(cnt[7:0], 8'h00);
    chk8({7'h0, o_oof}, 8'h00);
    chk8({7'h0, o_rejoin_ok}, 8'h01);
    // Far end now sends junk, so only the internal path can lock
    far_mode = 2'h2;
    wr(ADDR_CTRL, 8'h2E);
    wait_oof(1'b0);
    rx_find();
    wr(ADDR_GROUP, 8'h00);
    rdm(ADDR_STAT, 8'h00, 8'h10);
    wr(ADDR_CTRL, 8'h10);
    repeat (8)
    begin
      @(negedge i_clk);
      p = i_des_byte;
      @(negedge i_clk);
      chk8(o_ser_byte, p);
    end
    $display("loopback finished");
    test_done();
  end

  // About 24 frames are needed; the limit leaves ample margin under 100k cycles
  initial
  begin
    repeat (99000) @(posedge i_clk);
    mismatches++;
    test_done();
  end
endmodule
`default_nettype wire
